/* File: design/dbg_pkg.sv */
// package: debug register map, field positions, reset values and shared types
package dbg_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // register selectors
  localparam logic [4:0] SEL_CFG_STATUS = 5'h00;
  localparam logic [4:0] SEL_EXT_STATUS = 5'h01;
  localparam logic [4:0] SEL_SECOND_STATUS = 5'h02;
  localparam logic [4:0] SEL_THIRD_STATUS = 5'h03;
  localparam logic [4:0] SEL_HOST_ATTR = 5'h05;
  localparam logic [4:0] SEL_ADDR_ATTR_TRIG = 5'h06;
  localparam logic [4:0] SEL_TRIG_DEF = 5'h07;
  localparam logic [4:0] SEL_PC_CMP0 = 5'h08;
  localparam logic [4:0] SEL_PC_MASK = 5'h09;
  localparam logic [4:0] SEL_ADDR_HIGH = 5'h0c;
  localparam logic [4:0] SEL_ADDR_LOW = 5'h0d;
  localparam logic [4:0] SEL_DATA_VALUE = 5'h0e;
  localparam logic [4:0] SEL_DATA_MASK = 5'h0f;
  localparam logic [4:0] SEL_PC_CMP1 = 5'h18;
  localparam logic [4:0] SEL_PC_CMP2 = 5'h1a;
  localparam logic [4:0] SEL_PC_CMP3 = 5'h1b;
  localparam logic [4:0] SEL_LAST = 5'h1b;
  // trace buffer
  localparam int TRACE_DEPTH = 12;
  localparam logic [3:0] TRACE_LAST_INDEX = 4'hb;
  localparam logic [31:0] TRACE_MARK_ENTRY = 32'h0000001b;
  localparam logic [31:0] TRACE_STATE_BASE = 32'h00000020;
  // status register fields
  localparam int F_STATE_HI = 31;
  localparam int F_STATE_LO = 28;
  localparam int F_FOF = 27;
  localparam int F_TRG = 26;
  localparam int F_HALT = 25;
  localparam int F_BREAKPOINT_INPUT = 24;
  localparam int F_REV_HI = 23;
  localparam int F_REV_LO = 20;
  localparam int F_BKD = 18;
  localparam int F_VBD = 17;
  localparam int F_IPW = 16;
  localparam int F_TRC = 14;
  localparam int F_DDC_HI = 12;
  localparam int F_DDC_LO = 11;
  localparam int F_UHE = 10;
  localparam int F_BTB_HI = 9;
  localparam int F_BTB_LO = 8;
  localparam int F_NPL = 6;
  localparam int F_IPI = 5;
  localparam int F_SSM = 4;
  localparam int F_FID = 1;
  localparam int F_DDH = 0;
  localparam int F_BACKGROUND_MODE_ENABLE = 24;
  // writable control bits of the status register; everything else reads zero or is hardware owned
  localparam logic [31:0] CFG_CTRL_MASK = 32'h00075f73;
  localparam logic [31:0] LOW24_MASK = 32'h00ffffff;
  // reset values
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_RESET = 32'h00000000;
  localparam logic [31:0] ATTR_RESET = 32'h00000005;
  // breakpoint state codes
  localparam logic [3:0] BS_NONE = 4'h0;
  localparam logic [3:0] BS_WAIT1 = 4'h1;
  localparam logic [3:0] BS_TRIG1 = 4'h2;
  localparam logic [3:0] BS_WAIT2 = 4'h5;
  localparam logic [3:0] BS_TRIG2 = 4'h6;
  // data capture and branch target modes
  localparam logic [1:0] DDC_NONE = 2'h0;
  localparam logic [1:0] DDC_WRITE = 2'h1;
  localparam logic [1:0] DDC_READ = 2'h2;
  localparam logic [1:0] DDC_BOTH = 2'h3;
  localparam logic [1:0] BTB_NONE = 2'h0;
  localparam logic [1:0] BTB_TWO = 2'h1;
  // host command codes
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_READ_REG = 3'h1;
  localparam logic [2:0] CMD_WRITE_REG = 3'h2;
  localparam logic [2:0] CMD_WRITE_BYTE = 3'h3;
  localparam logic [2:0] CMD_READ_TRACE = 3'h4;
  localparam logic [2:0] CMD_HALT_REQ = 3'h5;
  localparam logic [2:0] CMD_RESUME = 3'h6;

  typedef struct packed {
    logic valid;
    logic [2:0] cmd;
    logic [4:0] sel;
    logic [31:0] data;
  } dbg_host_req_type;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dbg_host_rsp_type;

  typedef struct packed {
    logic valid;
    logic [4:0] sel;
    logic [31:0] data;
  } dbg_core_wr_type;

  typedef struct packed {
    logic halted;
    logic haltInsn;
    logic userMode;
    logic catastrophicHalt;
    logic triggerHalt;
    logic trigLevel1;
    logic trigLevel2;
    logic level2Enabled;
    logic traceFullHalt;
    logic samplePoint;
    logic traceException;
    logic instrDone;
    logic traceValid;
    logic [31:0] traceEntry;
  } dbg_core_evt_type;

  typedef struct packed {
    logic haltReq;
    logic debugIrq;
    logic haltIllegal;
    logic emulatorMode;
    logic nonPipelined;
    logic ignoreIrq;
    logic stepGrant;
  } dbg_core_ctl_type;

  typedef struct packed {
    logic [1:0] statusClk;
    logic [3:0] procStatus;
    logic [3:0] debugData;
    logic pinEnable;
  } dbg_vbus_type;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALTED = 3'b010,
    ST_STEP = 3'b100
  } dbg_exec_type;

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ext;
    logic [31:0] second;
    logic [31:0] third;
    logic [31:0] hostAttr;
    logic [31:0] addrAttr;
    logic [31:0] trigDef;
    logic [31:0] pc0;
    logic [31:0] pcMask;
    logic [31:0] addrHigh;
    logic [31:0] addrLow;
    logic [31:0] dataValue;
    logic [31:0] dataMask;
    logic [31:0] pc1;
    logic [31:0] pc2;
    logic [31:0] pc3;
    logic [TRACE_DEPTH-1:0][31:0] trace;
    logic [3:0] traceWr;
    logic afterMark;
    logic irqPending;
    logic irqActive;
    logic [2:0] bkptSync;
    logic bkptLevel;
    dbg_exec_type exec;
    dbg_host_rsp_type rsp;
    logic [1:0] statusClk;
    logic [3:0] capNibble;
  } dbg_state_type;
endpackage

/* File: design/dbg_register_map.sv */
// debug register file, status/config register and visibility-bus control
module dbg_register_map #(
  parameter logic [3:0] REVISION = 4'h3 // arbitrary value
) (
  // clock and reset
  input wire logic sysClk,
  input wire logic reset,
  // host debug port commands and answers
  input wire dbg_pkg::dbg_host_req_type hostReq,
  output dbg_pkg::dbg_host_rsp_type hostRsp,
  // core privileged write port
  input wire dbg_pkg::dbg_core_wr_type coreWr,
  // core events and control
  input wire dbg_pkg::dbg_core_evt_type coreEvt,
  output dbg_pkg::dbg_core_ctl_type coreCtl,
  // pins
  input wire logic breakpointInN,
  output dbg_pkg::dbg_vbus_type vbus,
  output logic debugModeOut
);
  timeunit 1ns;
  timeprecision 1ps;
  dbg_pkg::dbg_state_type s_q;
  dbg_pkg::dbg_state_type s_d;

  function automatic logic [31:0] merge_low24(input logic [31:0] oldV, input logic [31:0] newV);
    merge_low24 = (oldV & ~dbg_pkg::LOW24_MASK) | (newV & dbg_pkg::LOW24_MASK);
  endfunction

  logic hostWrite;
  logic coreWrite;
  logic anyWrite;
  logic [4:0] wrSel;
  logic [31:0] wrData;
  logic readStatus;
  logic bkptFall;
  logic bkptEvent;
  logic [3:0] breakpoint_state;
  logic [31:0] cfgView;

  always_comb begin
    hostWrite = hostReq.valid && hostReq.cmd == dbg_pkg::CMD_WRITE_REG && hostReq.sel <= dbg_pkg::SEL_LAST;
    coreWrite = coreWr.valid && !s_q.cfg[dbg_pkg::F_IPW] && !hostWrite;
    anyWrite = hostWrite || coreWrite;
    wrSel = hostWrite ? hostReq.sel : coreWr.sel;
    wrData = hostWrite ? hostReq.data : coreWr.data;
    readStatus = hostReq.valid && hostReq.cmd == dbg_pkg::CMD_READ_REG && hostReq.sel == dbg_pkg::SEL_CFG_STATUS;
    breakpoint_state = s_q.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO];
    // a fall is seen once the second and third stages agree low after a high
    bkptFall = s_q.bkptLevel && !s_q.bkptSync[1] && !s_q.bkptSync[2] && !s_q.cfg[dbg_pkg::F_VBD];
    bkptEvent = bkptFall || (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_HALT_REQ);
    cfgView = s_q.cfg;
    cfgView[dbg_pkg::F_REV_HI:dbg_pkg::F_REV_LO] = REVISION;
  end

  always_comb begin
    s_d = s_q;
    s_d.rsp = '0;
    s_d.bkptSync = {s_q.bkptSync[1:0], breakpointInN};
    if (s_q.bkptSync[1] == s_q.bkptSync[2]) begin
      s_d.bkptLevel = s_q.bkptSync[2];
    end
    // register writes; reserved bits of the status register stay zero
    if (anyWrite) begin
      case (wrSel)
        dbg_pkg::SEL_CFG_STATUS: begin
          s_d.cfg = (s_q.cfg & ~dbg_pkg::CFG_CTRL_MASK) | (wrData & dbg_pkg::CFG_CTRL_MASK);
          if (!hostWrite) begin
            s_d.cfg[dbg_pkg::F_IPW] = s_q.cfg[dbg_pkg::F_IPW];
          end
        end
        dbg_pkg::SEL_EXT_STATUS: s_d.ext = merge_low24(s_q.ext, wrData);
        dbg_pkg::SEL_SECOND_STATUS: s_d.second = merge_low24(s_q.second, wrData);
        dbg_pkg::SEL_THIRD_STATUS: s_d.third = merge_low24(s_q.third, wrData);
        dbg_pkg::SEL_HOST_ATTR: s_d.hostAttr = wrData;
        dbg_pkg::SEL_ADDR_ATTR_TRIG: s_d.addrAttr = wrData;
        dbg_pkg::SEL_TRIG_DEF: s_d.trigDef = wrData;
        dbg_pkg::SEL_PC_CMP0: s_d.pc0 = wrData;
        dbg_pkg::SEL_PC_MASK: s_d.pcMask = wrData;
        dbg_pkg::SEL_ADDR_HIGH: s_d.addrHigh = wrData;
        dbg_pkg::SEL_ADDR_LOW: s_d.addrLow = wrData;
        dbg_pkg::SEL_DATA_VALUE: s_d.dataValue = wrData;
        dbg_pkg::SEL_DATA_MASK: s_d.dataMask = wrData;
        dbg_pkg::SEL_PC_CMP1: s_d.pc1 = wrData;
        dbg_pkg::SEL_PC_CMP2: s_d.pc2 = wrData;
        dbg_pkg::SEL_PC_CMP3: s_d.pc3 = wrData;
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // top-byte writes, host only
    if (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_WRITE_BYTE) begin
      case (hostReq.sel)
        dbg_pkg::SEL_EXT_STATUS: s_d.ext[31:24] = hostReq.data[7:0];
        dbg_pkg::SEL_SECOND_STATUS: s_d.second[31:24] = hostReq.data[7:0];
        dbg_pkg::SEL_THIRD_STATUS: s_d.third[31:24] = hostReq.data[7:0];
        default: s_d.ext = s_d.ext;
      endcase
    end
    // breakpoint state: clears on read of a final trigger state (TRIG2, or TRIG1 without level 2) or on trigger write; new progress wins
    if (anyWrite && wrSel == dbg_pkg::SEL_TRIG_DEF) begin
      s_d.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO] = dbg_pkg::BS_NONE;
    end else if (readStatus && (breakpoint_state == dbg_pkg::BS_TRIG2 ||
        (breakpoint_state == dbg_pkg::BS_TRIG1 && !coreEvt.level2Enabled))) begin
      s_d.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO] = dbg_pkg::BS_NONE;
    end
    if (coreEvt.trigLevel2) begin
      s_d.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO] = dbg_pkg::BS_TRIG2;
    end else if (coreEvt.trigLevel1) begin
      s_d.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO] =
        coreEvt.level2Enabled ? dbg_pkg::BS_WAIT2 : dbg_pkg::BS_TRIG1;
    end else if (anyWrite && wrSel == dbg_pkg::SEL_TRIG_DEF && wrData != '0) begin
      s_d.cfg[dbg_pkg::F_STATE_HI:dbg_pkg::F_STATE_LO] = dbg_pkg::BS_WAIT1;
    end
    // halt cause flags: clear on read, all but FOF also on resume; set wins
    if (readStatus) begin
      s_d.cfg[dbg_pkg::F_FOF] = 1'b0;
    end
    if (readStatus || (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_RESUME)) begin
      s_d.cfg[dbg_pkg::F_TRG] = 1'b0;
      s_d.cfg[dbg_pkg::F_HALT] = 1'b0;
      s_d.cfg[dbg_pkg::F_BREAKPOINT_INPUT] = 1'b0;
    end
    if (coreEvt.catastrophicHalt) begin
      s_d.cfg[dbg_pkg::F_FOF] = 1'b1;
    end
    if (coreEvt.triggerHalt) begin
      s_d.cfg[dbg_pkg::F_TRG] = 1'b1;
    end
    if (coreEvt.haltInsn) begin
      s_d.cfg[dbg_pkg::F_HALT] = 1'b1;
    end
    if ((bkptEvent && !s_q.cfg[dbg_pkg::F_BKD]) || coreEvt.traceFullHalt) begin
      s_d.cfg[dbg_pkg::F_BREAKPOINT_INPUT] = 1'b1;
    end
    // debug interrupt: pending until sample point, no nesting
    if (bkptEvent && s_q.cfg[dbg_pkg::F_BKD] && !s_q.irqActive) begin
      s_d.irqPending = 1'b1;
    end
    if (coreEvt.samplePoint && s_q.irqPending) begin
      s_d.irqPending = 1'b0;
      s_d.irqActive = 1'b1;
    end
    if (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_RESUME) begin
      s_d.irqActive = 1'b0;
    end
    // trace buffer capture; entry after the marker carries the state
    if (coreEvt.traceValid) begin
      s_d.trace[s_q.traceWr] = s_q.afterMark ?
        dbg_pkg::TRACE_STATE_BASE + {27'h0, breakpoint_state, 1'b0} : coreEvt.traceEntry;
      s_d.afterMark = !s_q.afterMark && coreEvt.traceEntry == dbg_pkg::TRACE_MARK_ENTRY;
      s_d.traceWr = (s_q.traceWr == dbg_pkg::TRACE_LAST_INDEX) ? 4'h0 : s_q.traceWr + 4'h1;
    end
    // execution state for single step
    case (s_q.exec)
      dbg_pkg::ST_RUN: begin
        if (coreEvt.halted) begin
          s_d.exec = dbg_pkg::ST_HALTED;
        end
      end
      dbg_pkg::ST_HALTED: begin
        if (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_RESUME) begin
          s_d.exec = s_q.cfg[dbg_pkg::F_SSM] ? dbg_pkg::ST_STEP : dbg_pkg::ST_RUN;
        end
      end
      dbg_pkg::ST_STEP: begin
        if (coreEvt.instrDone) begin
          s_d.exec = dbg_pkg::ST_HALTED;
        end
      end
      default: s_d.exec = dbg_pkg::ST_RUN;
    endcase
    // host read answers, one cycle after the command
    if (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_READ_REG) begin
      s_d.rsp.valid = 1'b1;
      case (hostReq.sel)
        dbg_pkg::SEL_CFG_STATUS: s_d.rsp.data = cfgView;
        dbg_pkg::SEL_EXT_STATUS: s_d.rsp.data = s_q.ext;
        dbg_pkg::SEL_SECOND_STATUS: s_d.rsp.data = s_q.second;
        dbg_pkg::SEL_THIRD_STATUS: s_d.rsp.data = s_q.third;
        default: s_d.rsp.data = '0; // write-only registers read zero
      endcase
    end
    if (hostReq.valid && hostReq.cmd == dbg_pkg::CMD_READ_TRACE) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.data = (hostReq.sel[3:0] <= dbg_pkg::TRACE_LAST_INDEX) ? s_q.trace[hostReq.sel[3:0]] : '0;
    end
    // visibility bus: half-rate status clocks and operand nibbles
    s_d.statusClk = s_q.cfg[dbg_pkg::F_VBD] ? 2'h0 : {s_q.statusClk[0], ~s_q.statusClk[0]};
    case (s_q.cfg[dbg_pkg::F_DDC_HI:dbg_pkg::F_DDC_LO])
      dbg_pkg::DDC_WRITE: s_d.capNibble = coreEvt.traceEntry[3:0];
      dbg_pkg::DDC_READ: s_d.capNibble = coreEvt.traceEntry[7:4];
      dbg_pkg::DDC_BOTH: s_d.capNibble = coreEvt.traceEntry[3:0] ^ coreEvt.traceEntry[7:4];
      default: s_d.capNibble = (s_q.cfg[dbg_pkg::F_BTB_HI:dbg_pkg::F_BTB_LO] != dbg_pkg::BTB_NONE) ?
        coreEvt.traceEntry[11:8] : 4'h0;
    endcase
    if (s_q.cfg[dbg_pkg::F_VBD]) begin
      s_d.capNibble = 4'h0;
    end
    if (reset) begin
      s_d = '0;
      s_d.cfg = dbg_pkg::CFG_RESET;
      s_d.ext = dbg_pkg::ZERO_RESET;
      s_d.third = dbg_pkg::ZERO_RESET;
      s_d.hostAttr = dbg_pkg::ATTR_RESET;
      s_d.addrAttr = dbg_pkg::ATTR_RESET;
      s_d.bkptSync = 3'h7;
      s_d.bkptLevel = 1'b1;
      s_d.exec = dbg_pkg::ST_RUN;
    end
  end

  always_ff @(posedge sysClk) begin
    s_q <= s_d;
  end

  always_comb begin
    hostRsp = s_q.rsp;
    coreCtl.haltReq = s_q.cfg[dbg_pkg::F_BREAKPOINT_INPUT] || (s_q.exec == dbg_pkg::ST_STEP && coreEvt.instrDone);
    coreCtl.debugIrq = s_q.irqActive;
    // halt instruction needs background enable and the right privilege
    coreCtl.haltIllegal = coreEvt.haltInsn &&
      (!s_q.ext[dbg_pkg::F_BACKGROUND_MODE_ENABLE] || (coreEvt.userMode && !s_q.cfg[dbg_pkg::F_UHE]));
    coreCtl.emulatorMode = coreEvt.traceException && s_q.cfg[dbg_pkg::F_TRC];
    coreCtl.nonPipelined = s_q.cfg[dbg_pkg::F_NPL];
    coreCtl.ignoreIrq = s_q.cfg[dbg_pkg::F_SSM] && s_q.cfg[dbg_pkg::F_IPI];
    coreCtl.stepGrant = s_q.exec == dbg_pkg::ST_STEP;
    vbus.statusClk = s_q.statusClk;
    vbus.procStatus = s_q.cfg[dbg_pkg::F_VBD] ? 4'h0 : {breakpoint_state[2:0], 1'b0};
    vbus.debugData = s_q.capNibble;
    vbus.pinEnable = !s_q.cfg[dbg_pkg::F_VBD];
    debugModeOut = s_q.cfg[dbg_pkg::F_FID] || (coreEvt.halted && !s_q.cfg[dbg_pkg::F_DDH]);
  end
endmodule

/* File: test/dbg_host_model.sv */
// partner model: debug host issuing register, trace and run-control commands
module dbg_host_model (
  // clock
  input wire logic sysClk,
  // command out, answer in
  output dbg_pkg::dbg_host_req_type hostReq,
  input wire dbg_pkg::dbg_host_rsp_type hostRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hostReq = '0;
  // held for the one edge that takes it, then scrambled so stale fields cannot pass
  task automatic send(input logic [2:0] cmd, input logic [4:0] sel, input logic [31:0] data);
    @(negedge sysClk);
    hostReq = '{valid: 1'b1, cmd: cmd, sel: sel, data: data};
    @(negedge sysClk);
    hostReq = '{valid: 1'b0, cmd: ~cmd, sel: ~sel, data: ~data};
  endtask
  task automatic read(input logic [2:0] cmd, input logic [4:0] sel, output logic [31:0] data);
    send(cmd, sel, 32'h0);
    for (int i = 0; i < 3 && hostRsp.valid !== 1'b1; i++) @(negedge sysClk);
    data = (hostRsp.valid === 1'b1) ? hostRsp.data : 'x;
  endtask
endmodule

/* File: test/dbg_register_map_props.sv */
// checker: answer timing and status field relations at the debug register map ports
module dbg_register_map_props #(
  parameter logic [3:0] REVISION = 4'h3
) (
  // clock and reset
  input wire logic sysClk,
  input wire logic reset,
  // host and core side
  input wire dbg_pkg::dbg_host_req_type hostReq,
  input wire dbg_pkg::dbg_host_rsp_type hostRsp,
  input wire dbg_pkg::dbg_core_wr_type coreWr,
  input wire dbg_pkg::dbg_core_evt_type coreEvt,
  input wire dbg_pkg::dbg_core_ctl_type coreCtl,
  // pins
  input wire logic breakpointInN,
  input wire dbg_pkg::dbg_vbus_type vbus,
  input wire logic debugModeOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sysClk);
  endclocking
  default disable iff (reset);
  logic statusRd_q;
  logic quiet_q;
  wire logic rdReq = hostReq.valid && hostReq.cmd == dbg_pkg::CMD_READ_REG;
  wire logic trReq = hostReq.valid && hostReq.cmd == dbg_pkg::CMD_READ_TRACE;
  wire logic stRd = rdReq && hostReq.sel == dbg_pkg::SEL_CFG_STATUS;
  wire logic calm = !(coreEvt.catastrophicHalt || coreEvt.triggerHalt || coreEvt.haltInsn);
  always_ff @(posedge sysClk) begin
    if (reset) begin
      statusRd_q <= 1'b0;
      quiet_q <= 1'b0;
    end else begin
      statusRd_q <= stRd;
      quiet_q <= !vbus.pinEnable;
    end
  end
  // a halt event in the window would set a flag again, so the window must stay calm
  sequence rdCalm;
    stRd && calm;
  endsequence
  sequence twoReads;
    rdCalm ##1 calm ##1 rdCalm;
  endsequence
  a_read_answer: assert property (rdReq |=> hostRsp.valid) else $error("register read not answered");
  a_trace_answer: assert property (trReq |=> hostRsp.valid) else $error("trace read not answered");
  a_answer_only_reads: assert property (!(rdReq || trReq) |=> !hostRsp.valid)
    else $error("answer without a host read");
  a_revision_field: assert property (statusRd_q |-> hostRsp.data[23:20] == REVISION)
    else $error("revision field wrong");
  a_reserved_zero: assert property (statusRd_q |-> (hostRsp.data & ~(dbg_pkg::CFG_CTRL_MASK | 32'hfff00000)) == 32'h0)
    else $error("reserved status bit set");
  a_state_code: assert property (statusRd_q |-> hostRsp.data[31:28] inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6})
    else $error("illegal breakpoint state code");
  a_flags_cleared: assert property (twoReads |=> hostRsp.data[27:25] == 3'h0)
    else $error("halt cause flags survive a status read");
  a_pst_even: assert property (vbus.pinEnable |-> !vbus.procStatus[0]) else $error("status pins not twice state");
  // registered pins need one cycle to settle after the disable, so the check starts one cycle later
  a_bus_quiet: assert property (quiet_q && !vbus.pinEnable |-> vbus == '0)
    else $error("disabled bus not quiet");
endmodule

/* File: test/dbg_register_map_tb.sv */
// testbench: host and core access sequences against the debug register map
module dbg_register_map_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV = 4'h6; // arbitrary value
  localparam logic [31:0] REVF = {8'h00, REV, 20'h00000};
  localparam logic [31:0] DM_CFG [5] = '{32'h0, 32'h1, 32'h2, 32'h2, 32'h0};
  localparam logic DM_HALT [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic DM_EXP [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic sysClk = 1'b0;
  logic reset = 1'b1;
  dbg_pkg::dbg_host_req_type hostReq;
  dbg_pkg::dbg_host_rsp_type hostRsp;
  dbg_pkg::dbg_core_wr_type coreWr = '0;
  dbg_pkg::dbg_core_evt_type coreEvt = '0;
  dbg_pkg::dbg_core_evt_type ev;
  dbg_pkg::dbg_core_ctl_type coreCtl;
  dbg_pkg::dbg_vbus_type vbus;
  logic breakpointInN = 1'b1;
  logic debugModeOut;
  logic [31:0] rv;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  always #4 sysClk = ~sysClk;
  dbg_register_map #(.REVISION(REV)) dbg_register_map_inst (.sysClk(sysClk), .reset(reset), .hostReq(hostReq),
    .hostRsp(hostRsp), .coreWr(coreWr), .coreEvt(coreEvt), .coreCtl(coreCtl), .breakpointInN(breakpointInN),
    .vbus(vbus), .debugModeOut(debugModeOut));
  dbg_host_model dbg_host_model_inst (.sysClk(sysClk), .hostReq(hostReq), .hostRsp(hostRsp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wrReg(input logic [4:0] sel, input logic [31:0] data);
    dbg_host_model_inst.send(dbg_pkg::CMD_WRITE_REG, sel, data);
  endtask
  task automatic rdSt;
    dbg_host_model_inst.read(dbg_pkg::CMD_READ_REG, dbg_pkg::SEL_CFG_STATUS, rv);
  endtask
  task automatic coreWrite(input logic [4:0] sel, input logic [31:0] data);
    @(negedge sysClk);
    coreWr = '{valid: 1'b1, sel: sel, data: data};
    @(negedge sysClk);
    coreWr = '0;
  endtask
  task automatic pulse;
    @(negedge sysClk);
    coreEvt = ev;
    @(negedge sysClk);
    coreEvt = '0;
  endtask
  // a hang is cut well beyond the hundred or so cycles the sequence needs
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge sysClk);
    @(negedge sysClk);
    reset = 1'b0;
    rdSt();
    check(rv, REVF);
    dbg_host_model_inst.read(dbg_pkg::CMD_READ_REG, dbg_pkg::SEL_EXT_STATUS, rv);
    check(rv, dbg_pkg::ZERO_RESET);
    wrReg(dbg_pkg::SEL_CFG_STATUS, dbg_pkg::CFG_CTRL_MASK);
    rdSt();
    check(rv, dbg_pkg::CFG_CTRL_MASK | REVF);
    check(32'(vbus.pinEnable), 32'h0);
    breakpointInN = 1'b0;
    repeat (6) @(negedge sysClk);
    breakpointInN = 1'b1;
    rdSt();
    check(rv, dbg_pkg::CFG_CTRL_MASK | REVF);
    coreWrite(dbg_pkg::SEL_CFG_STATUS, 32'h0);
    rdSt();
    check(rv, dbg_pkg::CFG_CTRL_MASK | REVF);
    wrReg(dbg_pkg::SEL_CFG_STATUS, 32'h0);
    coreWrite(dbg_pkg::SEL_CFG_STATUS, 32'h00010012);
    rdSt();
    check(rv, 32'h00000012 | REVF);
    for (int i = 0; i < 5; i++) begin
      wrReg(dbg_pkg::SEL_CFG_STATUS, DM_CFG[i]);
      coreEvt.halted = DM_HALT[i];
      @(negedge sysClk);
      check(32'(debugModeOut), 32'(DM_EXP[i]));
    end
    coreEvt = '0;
    dbg_host_model_inst.send(dbg_pkg::CMD_WRITE_BYTE, dbg_pkg::SEL_EXT_STATUS, 32'h00000001);
    wrReg(dbg_pkg::SEL_EXT_STATUS, 32'h0);
    dbg_host_model_inst.read(dbg_pkg::CMD_READ_REG, dbg_pkg::SEL_EXT_STATUS, rv);
    check(rv & 32'h01000000, 32'h01000000);
    ev = '0;
    ev.catastrophicHalt = 1'b1;
    ev.triggerHalt = 1'b1;
    ev.haltInsn = 1'b1;
    ev.traceFullHalt = 1'b1;
    @(negedge sysClk);
    coreEvt = ev;
    @(negedge sysClk);
    check(32'(coreCtl.haltIllegal), 32'h0);
    coreEvt = '0;
    rdSt();
    check(rv, 32'h0f000000 | REVF);
    rdSt();
    check(rv, REVF);
    breakpointInN = 1'b0;
    repeat (2) @(negedge sysClk);
    breakpointInN = 1'b1;
    repeat (4) @(negedge sysClk);
    rdSt();
    check(rv, 32'h01000000 | REVF);
    ev = '0;
    ev.catastrophicHalt = 1'b1;
    ev.triggerHalt = 1'b1;
    pulse();
    dbg_host_model_inst.send(dbg_pkg::CMD_HALT_REQ, 5'h00, 32'h0);
    dbg_host_model_inst.send(dbg_pkg::CMD_RESUME, 5'h00, 32'h0);
    rdSt();
    check(rv, 32'h08000000 | REVF);
    dbg_host_model_inst.send(dbg_pkg::CMD_WRITE_BYTE, dbg_pkg::SEL_EXT_STATUS, 32'h0);
    @(negedge sysClk);
    coreEvt.haltInsn = 1'b1;
    @(negedge sysClk);
    check(32'(coreCtl.haltIllegal), 32'h1);
    coreEvt = '0;
    wrReg(dbg_pkg::SEL_TRIG_DEF, 32'h1);
    rdSt();
    check(rv & 32'hf0000000, 32'h10000000);
    check(32'(vbus.procStatus), 32'h2);
    ev = '0;
    ev.traceValid = 1'b1;
    ev.traceEntry = dbg_pkg::TRACE_MARK_ENTRY;
    pulse();
    ev.traceEntry = 32'h0000000f;
    pulse();
    dbg_host_model_inst.read(dbg_pkg::CMD_READ_TRACE, 5'h00, rv);
    check(rv, dbg_pkg::TRACE_MARK_ENTRY);
    dbg_host_model_inst.read(dbg_pkg::CMD_READ_TRACE, 5'h01, rv);
    check(rv, dbg_pkg::TRACE_STATE_BASE + 32'h2);
    ev = '0;
    ev.trigLevel1 = 1'b1;
    pulse();
    rdSt();
    check(rv & 32'hf0000000, 32'h20000000);
    rdSt();
    check(rv & 32'hf0000000, 32'h0);
    wrReg(dbg_pkg::SEL_TRIG_DEF, 32'h1);
    pulse();
    wrReg(dbg_pkg::SEL_TRIG_DEF, 32'h0);
    rdSt();
    check(rv & 32'hf0000000, 32'h0);
    // run controls: trace mode, pipelining and the step handshake
    coreEvt.traceException = 1'b1;
    #1 check(32'(coreCtl.emulatorMode), 32'h0);
    wrReg(dbg_pkg::SEL_CFG_STATUS, 32'h00004070);
    check(32'(coreCtl.emulatorMode), 32'h1);
    check(32'(coreCtl.nonPipelined), 32'h1);
    check(32'(coreCtl.ignoreIrq), 32'h1);
    coreEvt.halted = 1'b1;
    @(negedge sysClk);
    coreEvt = '0;
    dbg_host_model_inst.send(dbg_pkg::CMD_RESUME, 5'h00, 32'h0);
    check(32'(coreCtl.stepGrant), 32'h1);
    coreEvt.instrDone = 1'b1;
    #1 check(32'(coreCtl.haltReq), 32'h1);
    @(negedge sysClk);
    check(32'(coreCtl.stepGrant), 32'h0);
    coreEvt = '0;
    // breakpoint disabled: a halt request becomes an interrupt taken at the sample point
    wrReg(dbg_pkg::SEL_CFG_STATUS, 32'h00040000);
    dbg_host_model_inst.send(dbg_pkg::CMD_HALT_REQ, 5'h00, 32'h0);
    check(32'(coreCtl.debugIrq), 32'h0);
    check(32'(coreCtl.haltReq), 32'h0);
    coreEvt.samplePoint = 1'b1;
    @(negedge sysClk);
    coreEvt = '0;
    check(32'(coreCtl.debugIrq), 32'h1);
    // enabled bus: status clock runs, no capture selected shows nothing
    coreEvt.traceEntry = 32'h00000fff;
    rv = 32'(vbus.statusClk[0]);
    @(negedge sysClk);
    check(32'(vbus.statusClk[0]), rv ^ 32'h1);
    check(32'(vbus.debugData), 32'h0);
    // a second reset clears the fault flag and the active interrupt
    ev = '0;
    ev.catastrophicHalt = 1'b1;
    pulse();
    reset = 1'b1;
    repeat (2) @(negedge sysClk);
    reset = 1'b0;
    check(32'(coreCtl.debugIrq), 32'h0);
    rdSt();
    check(rv, REVF);
    results();
  end
endmodule
bind dbg_register_map dbg_register_map_props #(.REVISION(REVISION)) dbg_register_map_props_inst (.sysClk(sysClk),
  .reset(reset), .hostReq(hostReq), .hostRsp(hostRsp), .coreWr(coreWr), .coreEvt(coreEvt), .coreCtl(coreCtl),
  .breakpointInN(breakpointInN), .vbus(vbus), .debugModeOut(debugModeOut));
